//--- design/cictl_pkg.sv
// Constants, state layout and bus states of the core interrupt control
package cictl_pkg;
   // Register byte offsets
   localparam logic [7:0] ICTL_OFS = 8'h00;
   localparam logic [7:0] PCE_OFS  = 8'h04;
   localparam logic [7:0] STS_OFS  = 8'h08;
   localparam logic [7:0] MSK_OFS  = 8'h0C;
   localparam logic [7:0] PINS_OFS = 8'h10;
   localparam logic [7:0] CFG_OFS  = 8'h14;
   // Interrupt control bit positions
   localparam int GLB_EN_BIT = 7;
   localparam int PER_EN_BIT = 6;
   localparam int TMR_EN_BIT = 5;
   localparam int EXIE_BIT = 4;
   localparam int PCIE_BIT = 3;
   localparam int TOF_BIT  = 2;
   localparam int EXF_BIT  = 1;
   localparam int PCF_BIT  = 0;
   // Event status bit positions
   localparam int EV_TOF = 0;
   localparam int EV_EXT = 1;
   localparam int EV_PC  = 2;
   // Sizes
   localparam int NPC = 6;
   localparam int NEV = 3;
   // Reset values
   localparam logic [7:0]     ICTL_RST = 8'h00;
   localparam logic [NPC-1:0] PCE_RST  = 6'h00;
   localparam logic [NEV-1:0] STS_RST  = 3'h0;
   localparam logic [NEV-1:0] MSK_RST  = 3'h0;
   localparam logic           CFG_RST  = 1'h1;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACC  = 3'b010,
      BUS_END  = 3'b100
   } cictl_bus_t;

   typedef struct packed {
      logic           ext_s1;
      logic           ext_s2;
      logic           ext_d;
      logic [NPC-1:0] pc_s1;
      logic [NPC-1:0] pc_s2;
      logic [NPC-1:0] pc_d;
      logic [7:0]     ictl;
      logic [NPC-1:0] pce;
      logic           cfg_rise;
      logic [NEV-1:0] sts;
      logic [NEV-1:0] msk;
      cictl_bus_t     bus;
      logic           ap_write;
      logic [7:0]     ap_addr;
      logic           hready;
      logic [31:0]    hrdata;
      logic           core_irq;
      logic           irq;
   } cictl_state_t;
endpackage

//--- design/cictl_top.sv
// Core interrupt control register with AHB-Lite slave and event status
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cictl_top
   import cictl_pkg::*;
(
   input  wire logic           hclk,           // System clock
   input  wire logic           hresetn,        // Async reset, low
   input  wire logic           ce,             // Clock enable
   input  wire logic           hsel,           // Slave select
   input  wire logic [31:0]    haddr,          // Byte address
   input  wire logic [1:0]     htrans,         // Transfer type
   input  wire logic           hwrite,         // Write when high
   input  wire logic [2:0]     hsize,          // Word only
   input  wire logic [31:0]    hwdata,         // Write data
   input  wire logic           hready,         // Bus ready
   output logic                hreadyout,      // Slave ready
   output logic                hresp,          // Always OKAY
   output logic [31:0]         hrdata,         // Read data
   input  wire logic           timer_rollover, // Counter wrap pulse
   input  wire logic           periph_pending, // Peripheral request
   input  wire logic           ext_irq_pin,    // External pin
   input  wire logic [NPC-1:0] pc_pins,        // Change pins
   output logic                core_irq,       // Request to core
   output logic                irq             // Event interrupt
);
   cictl_state_t   st;
   cictl_state_t   nx;
   logic           accept;
   logic           wr_ictl;
   logic           ext_edge;
   logic           pc_evt;
   logic           core_src;
   logic [NPC-1:0] pc_chg;
   logic [7:0]     rd8;
   logic [7:0]     ev_bits;
   logic [NEV-1:0] ev;

   // Per-pin change detect, only pins enabled per pin count
   genvar gi;
   generate
      for (gi = 0; gi < NPC; gi++) begin : g_pc
         assign pc_chg[gi] = (st.pc_s2[gi] ^ st.pc_d[gi])
                             & st.pce[gi];
      end
   endgenerate

   // Event decode from synchronised pins
   assign ext_edge = st.cfg_rise ? (st.ext_s2 & ~st.ext_d)
                                 : (~st.ext_s2 & st.ext_d);
   assign pc_evt   = |pc_chg;
   assign accept   = hsel & hready & htrans[1];
   assign wr_ictl  = (st.bus == BUS_ACC) & st.ap_write
                     & (st.ap_addr == ICTL_OFS);

   // Flag sets ignore every ictl enable bit; pin changes still need pce
   always_comb begin
      ev_bits = 8'h00;
      ev_bits[TOF_BIT] = timer_rollover;
      ev_bits[EXF_BIT] = ext_edge;
      ev_bits[PCF_BIT] = pc_evt;
      ev = '0;
      ev[EV_TOF] = timer_rollover;
      ev[EV_EXT] = ext_edge;
      ev[EV_PC]  = pc_evt;
   end

   // Enabled core sources
   assign core_src = (st.ictl[TMR_EN_BIT] & st.ictl[TOF_BIT])
                   | (st.ictl[EXIE_BIT] & st.ictl[EXF_BIT])
                   | (st.ictl[PCIE_BIT] & st.ictl[PCF_BIT]);

   // Read mux; unmapped words read zero
   always_comb begin
      case (st.ap_addr)
         ICTL_OFS: rd8 = st.ictl;
         PCE_OFS:  rd8 = {2'h0, st.pce};
         STS_OFS:  rd8 = {5'h00, st.sts};
         MSK_OFS:  rd8 = {5'h00, st.msk};
         PINS_OFS: rd8 = {2'h0, st.pc_s2};
         CFG_OFS:  rd8 = {7'h00, st.cfg_rise};
         default:  rd8 = 8'h00;
      endcase
   end

   // Next state; hardware sets win over software clears
   always_comb begin
      nx = st;
      nx.ext_s1 = ext_irq_pin;
      nx.ext_s2 = st.ext_s1;
      nx.ext_d  = st.ext_s2;
      nx.pc_s1  = pc_pins;
      nx.pc_s2  = st.pc_s1;
      nx.pc_d   = st.pc_s2;
      nx.ictl   = st.ictl | ev_bits;
      nx.sts    = st.sts | ev;
      case (st.bus)
         BUS_IDLE: begin
            nx.hready = 1'b1;
            if (accept) begin
               nx.bus      = BUS_ACC;
               nx.ap_write = hwrite;
               nx.ap_addr  = haddr[7:0];
               nx.hready   = 1'b0;
            end
         end
         BUS_ACC: begin
            // One wait state keeps reads clear of a prior write
            nx.bus    = BUS_END;
            nx.hready = 1'b1;
            nx.hrdata = {24'h000000, rd8};
            if (st.ap_write) begin
               case (st.ap_addr)
                  ICTL_OFS: nx.ictl = hwdata[7:0] | ev_bits;
                  PCE_OFS:  nx.pce  = hwdata[NPC-1:0];
                  STS_OFS:  nx.sts  = (st.sts & ~hwdata[NEV-1:0]) | ev;
                  MSK_OFS:  nx.msk  = hwdata[NEV-1:0];
                  CFG_OFS:  nx.cfg_rise = hwdata[0];
                  default:  nx.hready = 1'b1;
               endcase
            end
         end
         BUS_END: begin
            nx.bus = BUS_IDLE;
            if (accept) begin
               nx.bus      = BUS_ACC;
               nx.ap_write = hwrite;
               nx.ap_addr  = haddr[7:0];
               nx.hready   = 1'b0;
            end
         end
         default: begin
            nx.bus    = BUS_IDLE;
            nx.hready = 1'b1;
         end
      endcase
      // Request lags the flags by one cycle, registered for timing
      nx.core_irq = st.ictl[GLB_EN_BIT]
                  & (core_src
                     | (st.ictl[PER_EN_BIT] & periph_pending));
      nx.irq = |(st.sts & st.msk);
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st          <= '0;
         st.ictl     <= ICTL_RST;
         st.pce      <= PCE_RST;
         st.sts      <= STS_RST;
         st.msk      <= MSK_RST;
         st.cfg_rise <= CFG_RST;
         st.bus      <= BUS_IDLE;
         st.hready   <= 1'b1;
      end else if (ce) begin
         st <= nx;
      end
   end

   // Outputs straight from the state register except hresp, tied to OKAY
   assign hreadyout = st.hready;
   assign hrdata    = st.hrdata;
   assign hresp     = 1'b0;
   assign core_irq  = st.core_irq;
   assign irq       = st.irq;

   // Timer flag follows a rollover
   AST_TOF_SET: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && timer_rollover |=> st.ictl[TOF_BIT])
      else $error("timer flag not set");

   // Timer flag stays until software writes the register
   AST_TOF_HOLD: assert property (
      @(posedge hclk) disable iff (!hresetn)
      st.ictl[TOF_BIT] && !wr_ictl |=> st.ictl[TOF_BIT])
      else $error("timer flag dropped by itself");

   // External edge sets its flag even with enables clear
   AST_EXT_SET: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && ext_edge && !st.ictl[GLB_EN_BIT] |=> st.ictl[EXF_BIT])
      else $error("external flag not set");

   // Pin change flag rises only with an enabled pin change or a control register write
   AST_PC_ONLY: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && !st.ictl[PCF_BIT] && !pc_evt && !wr_ictl
      |=> !st.ictl[PCF_BIT])
      else $error("pin change flag set without event");

   // Cleared global enable blocks the request
   AST_GLOBAL_OFF: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && !st.ictl[GLB_EN_BIT] |=> !core_irq)
      else $error("request with global enable clear");

   // Peripheral request needs the peripheral enable
   AST_PERIPH_OFF: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && !st.ictl[PER_EN_BIT] && !core_src |=> !core_irq)
      else $error("peripheral request not gated");

   // Pending pin change with both enables raises the request
   AST_PC_REQ: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && st.ictl[GLB_EN_BIT] && st.ictl[PCIE_BIT]
      && st.ictl[PCF_BIT] |=> core_irq)
      else $error("pin change request missing");

   // Pin change flag alone never requests
   AST_PC_GATE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && !st.ictl[PCIE_BIT] && !st.ictl[PER_EN_BIT]
      && !(st.ictl[TMR_EN_BIT] && st.ictl[TOF_BIT])
      && !(st.ictl[EXIE_BIT] && st.ictl[EXF_BIT]) |=> !core_irq)
      else $error("pin change request without enable");

   // Written byte lands in the register
   AST_ICTL_WR: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && wr_ictl && ev_bits == 8'h00
      |=> st.ictl == $past(hwdata[7:0]))
      else $error("control write lost");

   // Register is zero during reset
   AST_RST_ZERO: assert property (
      @(posedge hclk) !hresetn |=> st.ictl == 8'h00)
      else $error("control not zero in reset");

   // Every transfer ends one enabled cycle after its wait state
   AST_BUS_DONE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && st.bus == BUS_ACC ##1 ce |-> hreadyout)
      else $error("bus transfer not finished");

   // Every event sets its status bit whatever the mask
   AST_STS_SET: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && (ev != '0) |=> (st.sts & $past(ev)) == $past(ev))
      else $error("status bit not set by event");

   // Writing ones clears status unless an event lands
   AST_STS_W1C: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && st.bus == BUS_ACC && st.ap_write && st.ap_addr == STS_OFS
      && ev == '0 |=> (st.sts & $past(hwdata[NEV-1:0])) == '0)
      else $error("status write one did not clear");

   // Unmasked status raises the event interrupt
   AST_IRQ_ON: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && (st.sts & st.msk) != '0 |=> irq)
      else $error("event interrupt missing");

   // No unmasked status, no event interrupt
   AST_IRQ_OFF: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && (st.sts & st.msk) == '0 |=> !irq)
      else $error("event interrupt without cause");

   // External flag stays until software writes the register
   AST_EXT_HOLD: assert property (
      @(posedge hclk) disable iff (!hresetn)
      st.ictl[EXF_BIT] && !wr_ictl |=> st.ictl[EXF_BIT])
      else $error("external flag dropped by itself");

   // Enabled timer flag with global enable raises the request
   AST_TMR_REQ: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ce && st.ictl[GLB_EN_BIT] && st.ictl[TMR_EN_BIT]
      && st.ictl[TOF_BIT] |=> core_irq)
      else $error("timer request missing");

   // Low clock enable freezes every state bit, events are lost
   AST_CE_FREEZE: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !ce |=> $stable(st))
      else $error("state moved with clock enable low");

   // Main scenarios
   CV_REQ: cover property (
      @(posedge hclk) disable iff (!hresetn) $rose(core_irq));
   CV_EXT: cover property (
      @(posedge hclk) disable iff (!hresetn) ce && ext_edge);
   CV_PC: cover property (
      @(posedge hclk) disable iff (!hresetn) ce && pc_evt);
   CV_RD: cover property (
      @(posedge hclk) disable iff (!hresetn)
      st.bus == BUS_ACC && !st.ap_write && st.ap_addr == ICTL_OFS);
   CV_FREEZE: cover property (
      @(posedge hclk) disable iff (!hresetn) !ce && timer_rollover);
endmodule
`default_nettype wire

//--- sim/cictl_src_model.sv
// Behavioural model of the core side interrupt sources
`timescale 1ns/1ns
`default_nettype none
module cictl_src_model
   import cictl_pkg::*;
(
   input  wire logic      hclk,           // System clock
   output logic           timer_rollover, // Counter wrap pulse
   output logic           ext_irq_pin,    // External pin
   output logic [NPC-1:0] pc_pins,        // Change pins
   output logic           periph_pending  // Peripheral level
);
   // Quiet sources from time zero
   initial begin
      timer_rollover = 1'b0;
      ext_irq_pin    = 1'b0;
      pc_pins        = 6'h00;
      periph_pending = 1'b0;
   end
   // One-cycle wrap pulse, same clock as the block
   task automatic wrap();
      @(posedge hclk) timer_rollover <= 1'b1;
      @(posedge hclk) timer_rollover <= 1'b0;
   endtask
   // Pin and request levels change just after an edge
   task automatic drive(input logic e, input logic [NPC-1:0] p,
                        input logic q);
      @(posedge hclk);
      ext_irq_pin    <= e;
      pc_pins        <= p;
      periph_pending <= q;
   endtask
endmodule
`default_nettype wire

//--- sim/core_interrupt_control_bench.sv
// Self-checking bench for the core interrupt control block
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_control_bench;
   import cictl_pkg::*;
   logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]    haddr, hwdata, hrdata;
   logic [1:0]     htrans;
   logic           tmr, ext, pend, core_irq, irq;
   logic           ce;
   logic [NPC-1:0] pcp;
   int             num_errors = 0;
   int             compares = 0;
   int             cycles = 0;
   cictl_top cictl_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .timer_rollover(tmr), .periph_pending(pend), .ext_irq_pin(ext),
      .pc_pins(pcp), .core_irq(core_irq), .irq(irq));
   cictl_src_model cictl_src_model_inst (.hclk(hclk),
      .timer_rollover(tmr), .ext_irq_pin(ext), .pc_pins(pcp),
      .periph_pending(pend));
   // Free running clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Hang guard, well above the length of all scenarios
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, q);
      compares++;
      if (q !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, q);
      end
   endtask
   // One single transfer; ready and data are taken at rising edges
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, {24'h000000, d}, q);
   endtask
   task automatic rd(input string n, input logic [7:0] a,
                     input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(n, {24'h000000, e}, q);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Request level settles one edge after the register write; checked two falling edges on
   task automatic req(input logic e);
      repeat (2) @(negedge hclk);
      chk("core_irq", {31'h0, e}, {31'h0, core_irq});
   endtask
   task automatic t_reset();
      rd("ictl", ICTL_OFS, 8'h00);
      rd("unmapped", 8'h40, 8'h00);
      req(1'b0);
   endtask
   task automatic t_rw();
      wr(ICTL_OFS, 8'hF8);
      rd("ictl", ICTL_OFS, 8'hF8);
      req(1'b0);
      wr(ICTL_OFS, 8'h00);
      rd("ictl", ICTL_OFS, 8'h00);
   endtask
   task automatic t_timer();
      cictl_src_model_inst.wrap();
      repeat (20) @(posedge hclk);
      rd("timer flag", ICTL_OFS, 8'h04);
      req(1'b0);
      wr(ICTL_OFS, 8'h24);
      req(1'b0);
      wr(ICTL_OFS, 8'hA4);
      req(1'b1);
      rd("timer flag held", ICTL_OFS, 8'hA4);
      wr(ICTL_OFS, 8'hA0);
      req(1'b0);
      wr(ICTL_OFS, 8'h00);
   endtask
   task automatic t_ext();
      cictl_src_model_inst.drive(1'b1, 6'h00, 1'b0);
      repeat (6) @(posedge hclk);
      rd("ext flag", ICTL_OFS, 8'h02);
      wr(ICTL_OFS, 8'h92);
      req(1'b1);
      wr(ICTL_OFS, 8'h00);
      wr(ICTL_OFS, 8'h90);
      req(1'b0);
      wr(ICTL_OFS, 8'h00);
   endtask
   task automatic t_pc();
      cictl_src_model_inst.drive(1'b1, 6'h01, 1'b0);
      repeat (6) @(posedge hclk);
      rd("pc masked", ICTL_OFS, 8'h00);
      wr(PCE_OFS, 8'h01);
      cictl_src_model_inst.drive(1'b1, 6'h00, 1'b0);
      repeat (6) @(posedge hclk);
      rd("pc flag", ICTL_OFS, 8'h01);
      wr(ICTL_OFS, 8'h89);
      req(1'b1);
      wr(ICTL_OFS, 8'h81);
      req(1'b0);
      wr(ICTL_OFS, 8'h00);
   endtask
   task automatic t_periph();
      cictl_src_model_inst.drive(1'b1, 6'h00, 1'b1);
      wr(ICTL_OFS, 8'h80);
      req(1'b0);
      wr(ICTL_OFS, 8'h40);
      req(1'b0);
      wr(ICTL_OFS, 8'hC0);
      req(1'b1);
      cictl_src_model_inst.drive(1'b1, 6'h00, 1'b0);
      req(1'b0);
      wr(ICTL_OFS, 8'h00);
   endtask
   task automatic t_status();
      rd("status", STS_OFS, 8'h07);
      wr(MSK_OFS, 8'h00);
      repeat (2) @(negedge hclk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(MSK_OFS, 8'h01);
      repeat (2) @(negedge hclk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(STS_OFS, 8'h07);
      repeat (2) @(negedge hclk);
      chk("irq", 32'h0, {31'h0, irq});
      rd("status", STS_OFS, 8'h00);
   endtask
   // Falling edge mode, pin levels and readback of side registers
   task automatic t_cfg();
      rd("cfg", CFG_OFS, 8'h01);
      rd("pce", PCE_OFS, 8'h01);
      rd("mask", MSK_OFS, 8'h01);
      wr(CFG_OFS, 8'h00);
      rd("cfg", CFG_OFS, 8'h00);
      cictl_src_model_inst.drive(1'b0, 6'h2A, 1'b0);
      repeat (6) @(posedge hclk);
      rd("pins", PINS_OFS, 8'h2A);
      rd("ext fall flag", ICTL_OFS, 8'h02);
      wr(ICTL_OFS, 8'h00);
   endtask
   // A wrap while the clock enable is low is not seen
   task automatic t_freeze();
      @(posedge hclk);
      ce <= 1'b0;
      cictl_src_model_inst.wrap();
      @(posedge hclk);
      ce <= 1'b1;
      rd("frozen flag", ICTL_OFS, 8'h00);
   endtask
   // Main sequence, bus idle and reset held from time zero
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_rw();
      t_timer();
      t_ext();
      t_pc();
      t_periph();
      t_status();
      t_cfg();
      t_freeze();
      report_and_stop();
   end
endmodule
`default_nettype wire
